//--- core/ofe_regs_pkg.sv
// constants, field layouts and types for the optical front end register slice
package ofe_regs_pkg;
   localparam int          ADDR_W            = 8;
   localparam int          DATA_W            = 24;
   localparam int          COUNT_W           = 16;
   localparam int          SEL_W             = 3;
   localparam int          DIV_W             = 4;
   // register offsets
   localparam logic [7:0]  FIRST_LED_OFFSET  = 8'h2c;
   localparam logic [7:0]  DIFF_OFFSET       = 8'h2f;
   localparam logic [7:0]  CTRL_OFFSET       = 8'h31;
   localparam logic [7:0]  WIN_START_OFFSET  = 8'h32;
   localparam logic [7:0]  WIN_END_OFFSET    = 8'h33;
   // control register fields
   localparam int          DETACH_BIT        = 10;
   localparam int          SHORT_BIT         = 5;
   localparam int          SEL_LSB           = 0;
   // reset values
   localparam logic [23:0] RESULT_RESET      = 24'h000000;
   localparam logic [15:0] COUNT_RESET       = 16'h0000;
   localparam logic [2:0]  SEL_RESET         = 3'h0;
   // divider codes and ratios
   localparam logic [2:0]  SEL_DIV2          = 3'h0;
   localparam logic [2:0]  SEL_DIV8          = 3'h1;
   localparam logic [2:0]  SEL_DIV12         = 3'h3;
   localparam logic [2:0]  SEL_DIV4          = 3'h4;
   localparam logic [2:0]  SEL_DIV1          = 3'h5;
   localparam logic [2:0]  SEL_DIV6          = 3'h6;
   localparam logic [3:0]  RATIO_1           = 4'h1;
   localparam logic [3:0]  RATIO_2           = 4'h2;
   localparam logic [3:0]  RATIO_4           = 4'h4;
   localparam logic [3:0]  RATIO_6           = 4'h6;
   localparam logic [3:0]  RATIO_8           = 4'h8;
   localparam logic [3:0]  RATIO_12          = 4'hc;

   typedef struct packed {
      logic       photodiode_detach;
      logic       input_short_on_powerdown;
      logic [2:0] external_clock_divider_select;
   } control_s;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [23:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic        valid;
      logic [23:0] code;
   } sample_s;
endpackage

//--- core/optical_frontend_config_regs.sv
// register slice of the optical front end: results, input control, divider, power-down window
//
// Contract
// - read-only first LED minus ambient result
// - detach disconnects both photodiode inputs
// - detach stops photodiode bias drive
// - input short ties inputs while amplifier down
// - external clock divided by selected ratio
// - readable writable window start count
// - readable writable window end count
// - read-only first LED sample result
module optical_frontend_config_regs
   import ofe_regs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire reg_req_s    reg_req,
   output logic [23:0]      reg_rdata,
   output logic             reg_rvalid,
   input  wire sample_s     first_led_sample,
   input  wire sample_s     ambient_sample,
   input  wire logic        external_clock_mode,
   input  wire logic        amplifier_powered_down,
   input  wire logic [15:0] timing_engine_count,
   output logic [23:0]      first_led_code,
   output logic [23:0]      first_led_minus_ambient_code,
   output logic             photodiode_input_pos_connect,
   output logic             photodiode_input_neg_connect,
   output logic             photodiode_bias_enable,
   output logic             inputs_to_common_mode,
   output logic             divided_clock_tick,
   output logic             dynamic_powerdown_window
);

   // ratio decode, shared by the divider and its checks
   function automatic logic [3:0] div_ratio(input logic [2:0] sel);
      case (sel)
         SEL_DIV2:  div_ratio = RATIO_2;
         SEL_DIV8:  div_ratio = RATIO_8;
         SEL_DIV12: div_ratio = RATIO_12;
         SEL_DIV4:  div_ratio = RATIO_4;
         SEL_DIV1:  div_ratio = RATIO_1;
         SEL_DIV6:  div_ratio = RATIO_6;
         // forbidden codes fall back to a ratio of two
         default:   div_ratio = RATIO_2;
      endcase
   endfunction

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
      is_addr = (a == off);
   endfunction

   control_s    ctrl_reg, ctrl_next;
   logic [15:0] start_reg, start_next;
   logic [15:0] end_reg, end_next;
   logic [23:0] led_reg, led_next;
   logic [23:0] diff_reg, diff_next;
   logic [23:0] rdata_reg, rdata_next;
   logic        rvalid_reg, rvalid_next;
   logic [3:0]  div_cnt_reg, div_cnt_next;
   logic        tick_reg, tick_next;
   logic        pos_reg, neg_reg, bias_reg, short_reg, win_reg;
   logic        pos_next, neg_next, bias_next, short_next, win_next;

   // register writes; unused bits are simply not stored
   always_comb begin
      ctrl_next  = ctrl_reg;
      start_next = start_reg;
      end_next   = end_reg;
      if (reg_req.wr) begin
         if (is_addr(reg_req.addr, CTRL_OFFSET)) begin
            ctrl_next.photodiode_detach             = reg_req.wdata[DETACH_BIT];
            ctrl_next.input_short_on_powerdown      = reg_req.wdata[SHORT_BIT];
            ctrl_next.external_clock_divider_select = reg_req.wdata[SEL_LSB +: SEL_W];
         end
         if (is_addr(reg_req.addr, WIN_START_OFFSET)) begin
            start_next = reg_req.wdata[COUNT_W-1:0];
         end
         if (is_addr(reg_req.addr, WIN_END_OFFSET)) begin
            end_next = reg_req.wdata[COUNT_W-1:0];
         end
      end
   end

   // results; the difference is formed when the ambient sample lands
   always_comb begin
      led_next  = led_reg;
      diff_next = diff_reg;
      if (first_led_sample.valid) begin
         led_next = first_led_sample.code;
      end
      if (ambient_sample.valid) begin
         diff_next = led_next - ambient_sample.code;
      end
   end

   // read port: one cycle latency, unmapped and write-only bits read zero
   always_comb begin
      rdata_next  = 24'h000000;
      rvalid_next = reg_req.rd;
      if (reg_req.rd) begin
         case (reg_req.addr)
            FIRST_LED_OFFSET: rdata_next = led_reg;
            DIFF_OFFSET:      rdata_next = diff_reg;
            CTRL_OFFSET: begin
               rdata_next[SHORT_BIT]             = ctrl_reg.input_short_on_powerdown;
               rdata_next[SEL_LSB +: SEL_W]      = ctrl_reg.external_clock_divider_select;
            end
            WIN_START_OFFSET: rdata_next[COUNT_W-1:0] = start_reg;
            WIN_END_OFFSET:   rdata_next[COUNT_W-1:0] = end_reg;
            default:          rdata_next = 24'h000000;
         endcase
      end
   end

   // divider and analog steering
   always_comb begin
      logic [3:0] ratio;
      ratio        = div_ratio(ctrl_reg.external_clock_divider_select);
      div_cnt_next = 4'h0;
      tick_next    = 1'b0;
      if (external_clock_mode) begin
         if (div_cnt_reg >= ratio - 4'h1) begin
            tick_next = 1'b1;
         end else begin
            div_cnt_next = div_cnt_reg + 4'h1;
         end
      end
      pos_next   = !ctrl_reg.photodiode_detach;
      neg_next   = !ctrl_reg.photodiode_detach;
      bias_next  = !ctrl_reg.photodiode_detach;
      short_next = ctrl_reg.input_short_on_powerdown && amplifier_powered_down;
      win_next   = (timing_engine_count >= start_reg)
                   && (timing_engine_count <= end_reg);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg    <= '{photodiode_detach: 1'b0, input_short_on_powerdown: 1'b0,
                          external_clock_divider_select: SEL_RESET};
         start_reg   <= COUNT_RESET;
         end_reg     <= COUNT_RESET;
         led_reg     <= RESULT_RESET;
         diff_reg    <= RESULT_RESET;
         rdata_reg   <= RESULT_RESET;
         rvalid_reg  <= 1'b0;
         div_cnt_reg <= 4'h0;
         tick_reg    <= 1'b0;
         pos_reg     <= 1'b1;
         neg_reg     <= 1'b1;
         bias_reg    <= 1'b1;
         short_reg   <= 1'b0;
         win_reg     <= 1'b0;
      end else begin
         ctrl_reg    <= ctrl_next;
         start_reg   <= start_next;
         end_reg     <= end_next;
         led_reg     <= led_next;
         diff_reg    <= diff_next;
         rdata_reg   <= rdata_next;
         rvalid_reg  <= rvalid_next;
         div_cnt_reg <= div_cnt_next;
         tick_reg    <= tick_next;
         pos_reg     <= pos_next;
         neg_reg     <= neg_next;
         bias_reg    <= bias_next;
         short_reg   <= short_next;
         win_reg     <= win_next;
      end
   end

   assign reg_rdata                    = rdata_reg;
   assign reg_rvalid                   = rvalid_reg;
   assign first_led_code               = led_reg;
   assign first_led_minus_ambient_code = diff_reg;
   assign photodiode_input_pos_connect = pos_reg;
   assign photodiode_input_neg_connect = neg_reg;
   assign photodiode_bias_enable       = bias_reg;
   assign inputs_to_common_mode        = short_reg;
   assign divided_clock_tick           = tick_reg;
   assign dynamic_powerdown_window     = win_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_diff_result: assert property (
      ambient_sample.valid && !first_led_sample.valid
      |=> first_led_minus_ambient_code == $past(led_reg) - $past(ambient_sample.code))
      else $error("difference result wrong");
   chk_diff_readonly: assert property (
      reg_req.wr && is_addr(reg_req.addr, DIFF_OFFSET) && !ambient_sample.valid
      |=> $stable(first_led_minus_ambient_code))
      else $error("difference result changed by a write");
   chk_detach_inputs: assert property (
      ctrl_reg.photodiode_detach
      |=> !photodiode_input_pos_connect && !photodiode_input_neg_connect)
      else $error("photodiode still connected while detached");
   chk_detach_bias: assert property (
      reg_req.wr && is_addr(reg_req.addr, CTRL_OFFSET) && reg_req.wdata[DETACH_BIT]
      |-> ##2 !photodiode_bias_enable)
      else $error("bias still driven while detached");
   chk_short_powerdown: assert property (
      inputs_to_common_mode == $past(ctrl_reg.input_short_on_powerdown && amplifier_powered_down))
      else $error("input short does not follow amplifier power-down");
   chk_div_period: assert property (
      divided_clock_tick && external_clock_mode && $stable(ctrl_reg)
      && div_ratio(ctrl_reg.external_clock_divider_select) == RATIO_4
      |-> ##1 !divided_clock_tick ##1 !divided_clock_tick ##1 !divided_clock_tick)
      else $error("divide by four period wrong");
   chk_start_write: assert property (
      reg_req.wr && is_addr(reg_req.addr, WIN_START_OFFSET) ##1 !reg_req.wr
      ##1 reg_req.rd && is_addr(reg_req.addr, WIN_START_OFFSET) && !reg_req.wr
      |=> reg_rvalid && reg_rdata == {8'h00, $past(reg_req.wdata[15:0], 3)})
      else $error("start count not read back");
   chk_end_write: assert property (
      reg_req.wr && is_addr(reg_req.addr, WIN_END_OFFSET)
      |=> end_reg == $past(reg_req.wdata[15:0]))
      else $error("end count not stored");
   chk_led_store: assert property (
      first_led_sample.valid |=> first_led_code == $past(first_led_sample.code))
      else $error("first LED sample not stored");
   chk_window_span: assert property (
      $stable(start_reg) && $stable(end_reg)
      |=> dynamic_powerdown_window == ($past(timing_engine_count) >= $past(start_reg)
                                       && $past(timing_engine_count) <= $past(end_reg)))
      else $error("power-down window wrong");

   cov_detach:     cover property (ctrl_reg.photodiode_detach ##1 !photodiode_bias_enable);
   cov_short:      cover property (inputs_to_common_mode);
   cov_window:     cover property (!dynamic_powerdown_window ##1 dynamic_powerdown_window);
   cov_div12_tick: cover property (divided_clock_tick && ctrl_reg.external_clock_divider_select
                                   == SEL_DIV12);
endmodule // optical_frontend_config_regs

//--- tb/host_model.sv
// host side model: drives the register port that the serial slave engine feeds
module host_model
   import ofe_regs_pkg::*;
(
   input  wire logic        clk,
   output reg_req_s         reg_req,
   input  wire logic [23:0] reg_rdata,
   input  wire logic        reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial reg_req = '0;
   // released address and data are inverted so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(negedge clk) reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk) reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic rd(input logic [7:0] a, output logic [23:0] d, output logic ok);
      int i;
      ok = 1'b0;
      d = 24'h000000;
      @(negedge clk) reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h000000};
      @(negedge clk) reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 24'hffffff};
      for (i = 0; i < 3 && !ok; i++) begin
         if (reg_rvalid === 1'b1) begin
            d = reg_rdata;
            ok = 1'b1;
         end
         else @(negedge clk);
      end
   endtask
endmodule // host_model

//--- tb/tb.sv
// self-checking bench for the optical front end register slice
module tb
   import ofe_regs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, sys_rst = 1'b1, reg_rvalid, ext_mode = 1'b0, amp_down = 1'b0;
   logic        pos_c, neg_c, bias_en, to_cm, tick, win;
   logic [23:0] reg_rdata, led_code, diff_code;
   logic [15:0] te_count = 16'h0000;
   reg_req_s    reg_req;
   sample_s     led_s = '0, amb_s = '0;
   int          fail_count = 0, checks = 0;
   always #5 clk = ~clk;
   host_model host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   optical_frontend_config_regs dut (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .first_led_sample(led_s),
      .ambient_sample(amb_s), .external_clock_mode(ext_mode), .amplifier_powered_down(amp_down),
      .timing_engine_count(te_count), .first_led_code(led_code),
      .first_led_minus_ambient_code(diff_code), .photodiode_input_pos_connect(pos_c),
      .photodiode_input_neg_connect(neg_c), .photodiode_bias_enable(bias_en),
      .inputs_to_common_mode(to_cm), .divided_clock_tick(tick), .dynamic_powerdown_window(win));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [23:0] exp);
      logic [23:0] d;
      logic        ok;
      host.rd(a, d, ok);
      chk({23'h0, ok}, 24'h000001);
      chk(d, exp);
   endtask
   task automatic feed(input logic led, input logic [23:0] c);
      @(negedge clk);
      if (led) led_s = '{valid: 1'b1, code: c};
      else amb_s = '{valid: 1'b1, code: c};
      @(negedge clk);
      led_s = '{valid: 1'b0, code: ~c};
      amb_s = '{valid: 1'b0, code: ~c};
   endtask
   task automatic t_reset();
      chk({20'h0, pos_c, neg_c, bias_en, to_cm}, 24'h00000e);
      rchk(DIFF_OFFSET, RESULT_RESET);
      rchk(FIRST_LED_OFFSET, RESULT_RESET);
      rchk(CTRL_OFFSET, 24'h000000);
      rchk(WIN_START_OFFSET, 24'h000000);
      rchk(WIN_END_OFFSET, 24'h000000);
      rchk(8'h40, 24'h000000);
   endtask
   task automatic t_samples();
      feed(1'b1, 24'h00000a);
      feed(1'b0, 24'h000003);
      chk(diff_code, 24'h000007);
      feed(1'b1, 24'h000003);
      feed(1'b0, 24'h00000a);
      chk(led_code, 24'h000003);
      host.wr(DIFF_OFFSET, 24'h000000);
      host.wr(FIRST_LED_OFFSET, 24'h000000);
      rchk(DIFF_OFFSET, 24'hfffff9);
      rchk(FIRST_LED_OFFSET, 24'h000003);
   endtask
   task automatic t_ctrl();
      host.wr(CTRL_OFFSET, 24'h000426);
      @(negedge clk);
      chk({21'h0, pos_c, neg_c, bias_en}, 24'h000000);
      rchk(CTRL_OFFSET, 24'h000026);
      amp_down = 1'b1;
      @(negedge clk);
      chk({23'h0, to_cm}, 24'h000001);
      host.wr(CTRL_OFFSET, 24'h000005);
      @(negedge clk);
      chk({20'h0, pos_c, neg_c, bias_en, to_cm}, 24'h00000e);
      amp_down = 1'b0;
   endtask
   task automatic t_divider();
      // only the listed codes are programmed, forbidden ones never
      logic [2:0] codes[6] = '{SEL_DIV2, SEL_DIV8, SEL_DIV12, SEL_DIV4, SEL_DIV1,
                               SEL_DIV6};
      logic [3:0] ratio[6] = '{RATIO_2, RATIO_8, RATIO_12, RATIO_4, RATIO_1, RATIO_6};
      int i, g, n;
      for (i = 0; i < 6; i++) begin
         ext_mode = 1'b0;
         host.wr(CTRL_OFFSET, {21'h0, codes[i]});
         ext_mode = 1'b1;
         for (g = 0; g < 30 && tick !== 1'b1; g++) @(negedge clk);
         chk({23'h0, tick}, 24'h000001);
         if (g >= 30) give_verdict();
         @(negedge clk);
         for (n = 1; n < 30 && tick !== 1'b1; n++) @(negedge clk);
         chk(24'(n), {20'h0, ratio[i]});
         if (n >= 30) give_verdict();
      end
      ext_mode = 1'b0;
   endtask
   task automatic sweep(input logic [15:0] s, input logic [15:0] e);
      int c;
      host.wr(WIN_START_OFFSET, {8'h00, s});
      rchk(WIN_START_OFFSET, {8'h00, s});
      host.wr(WIN_END_OFFSET, {8'h00, e});
      rchk(WIN_END_OFFSET, {8'h00, e});
      for (c = 0; c < 11; c++) begin
         te_count = 16'(c);
         @(negedge clk);
         chk({23'h0, win}, {23'h0, (c >= s && c <= e)});
      end
   endtask
   initial begin
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      t_reset();
      t_samples();
      t_ctrl();
      t_divider();
      sweep(16'h0005, 16'h0008);
      sweep(16'h0009, 16'h0003);
      give_verdict();
   end
endmodule // tb
